/* common/kms_defs.svh */
// constants of the key matrix scanner: register map, fields, reset values, timing
// Overview of operation
// - While the execution condition is off, no scan step runs and the row drive, the error flag and the key map bits that software does not clear hold.
// - While enabled, all 64 positions of the 8 by 8 matrix are sampled and recorded.
// - Row-select bits 0 to 7 are driven in ascending order, each for three executions.
// - At most one row-select bit is high at any time.
// - After row 7, bit 8 is driven for three executions as end-of-round, then row 0 follows.
// - A key is located from the active row index and the index of the column input that is high.
// - Keys 0-15, 16-31, 32-47 and 48-63 set bits 0-15 of key map words 0, 1, 2 and 3.
// - The matrix uses exactly eight column inputs and nine row-select outputs, bit 8 marking end-of-round.
// - With nine phases held three executions each, a key waits at most 25 executions for its row.
// - Scanning starts at row 0 on the first execution after run is first set following reset; setting run again resumes at the held phase.
// - The executing flag is high while the scanner runs and low in an interlocked section.
// - In an interlocked section no scan step runs.
// - The error flag rises when an indirect destination pointer is not BCD or runs past memory.
`ifndef KMS_DEFS_SVH
`define KMS_DEFS_SVH

// register byte offsets
`define KMS_OFS_CTRL 8'h00
`define KMS_OFS_STATUS 8'h04
`define KMS_OFS_MAP0 8'h08
`define KMS_OFS_MAP1 8'h0C
`define KMS_OFS_MAP2 8'h10
`define KMS_OFS_MAP3 8'h14
`define KMS_OFS_IRQ_STAT 8'h18
`define KMS_OFS_IRQ_MASK 8'h1C
`define KMS_OFS_DEST 8'h20

// control fields
`define KMS_CTRL_RUN 0
`define KMS_CTRL_ILOCK 1
`define KMS_CTRL_INDIR 2
`define KMS_CTRL_RST 3'h0

// status fields
`define KMS_ST_BUSY 0
`define KMS_ST_ERR 1
`define KMS_ST_PHASE_LO 8

// interrupt bits
`define KMS_IRQ_ROUND 0
`define KMS_IRQ_KEY 1
`define KMS_IRQ_ERR 2
`define KMS_IRQ_RST 3'h0

// destination pointer reset and highest data memory word (bcd digits as decimal)
`define KMS_DEST_RST 16'h0000
`define KMS_DM_LAST 9999

// timing in executions and matrix size
`define KMS_HOLD_EXECS 3
`define KMS_ROWS 8
`define KMS_COLS 8

`endif

/* common/kms_pkg.sv */
// types of the key matrix scanner
package kms_pkg;

  typedef enum logic [3:0] {
    KMS_PH_ROW0 = 4'b0000,
    KMS_PH_ROW1 = 4'b0001,
    KMS_PH_ROW2 = 4'b0010,
    KMS_PH_ROW3 = 4'b0011,
    KMS_PH_ROW4 = 4'b0100,
    KMS_PH_ROW5 = 4'b0101,
    KMS_PH_ROW6 = 4'b0110,
    KMS_PH_ROW7 = 4'b0111,
    KMS_PH_EOR = 4'b1000
  } kms_phase_t;

  typedef struct packed {
    kms_phase_t phase;
    logic [1:0] hold;
    logic [8:0] row_sel;
    logic round_done;
  } kms_cnt_state_t;

  typedef struct packed {
    logic [7:0] col_s1;
    logic [7:0] col_s2;
    logic [63:0] key_map;
    logic [2:0] ctrl;
    logic [15:0] dest;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic err;
    logic [31:0] rdata;
  } kms_top_state_t;

endpackage : kms_pkg

/* common/kms_phase_if.sv */
// link between the scanner core and its phase counter
`timescale 1ns/100ps
interface kms_phase_if;
  import kms_pkg::*;
  logic step;
  kms_phase_t phase;
  logic [8:0] row_sel;
  logic round_done;

  modport core (
    output step,
    input phase,
    input row_sel,
    input round_done
  );

  modport cnt (
    input step,
    output phase,
    output row_sel,
    output round_done
  );
endinterface : kms_phase_if

/* rtl/kms_phase.sv */
// phase counter: row 0 to 7 and end-of-round, each held for a fixed number of executions
`timescale 1ns/100ps
`include "kms_defs.svh"
module kms_phase #(
  parameter int HOLD = `KMS_HOLD_EXECS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link to the core
  kms_phase_if.cnt pif
);
  import kms_pkg::*;

  generate
    if (HOLD < 1 || HOLD > 4) begin : g_bad_hold
      $error("kms_phase: HOLD must lie in 1..4");
    end
  endgenerate

  localparam logic [1:0] HOLD_LAST = 2'(HOLD - 1);

  kms_cnt_state_t s_q;
  kms_cnt_state_t s_d;

  function automatic kms_phase_t next_phase(input kms_phase_t p);
    kms_phase_t n;
    n = KMS_PH_ROW0;
    case (p)
      KMS_PH_EOR: n = KMS_PH_ROW0;
      default: n = kms_phase_t'(4'(p) + 4'h1);
    endcase
    return n;
  endfunction : next_phase

  always_comb begin
    s_d = s_q;
    s_d.round_done = 1'b0;
    if (pif.step) begin
      if (s_q.hold == HOLD_LAST) begin
        s_d.hold = 2'h0;
        s_d.phase = next_phase(s_q.phase);
        s_d.row_sel = 9'h001 << 4'(s_d.phase);
        s_d.round_done = (s_q.phase == KMS_PH_EOR);
      end else begin
        s_d.hold = s_q.hold + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.phase <= KMS_PH_ROW0;
      s_q.hold <= 2'h0;
      s_q.row_sel <= 9'h001;
      s_q.round_done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.phase = s_q.phase;
  assign pif.row_sel = s_q.row_sel;
  assign pif.round_done = s_q.round_done;

endmodule : kms_phase

/* rtl/kms_top.sv */
// key matrix scanner: row drive, column sampling, key map, registers and interrupt
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "kms_defs.svh"
module kms_top #(
  parameter int ROWS = `KMS_ROWS,
  parameter int COLS = `KMS_COLS,
  parameter int HOLD = `KMS_HOLD_EXECS,
  parameter int DM_LAST = `KMS_DM_LAST
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // controller execution
  input wire logic scan_tick,
  // matrix pins
  input wire logic [7:0] column_input_word,
  output logic [8:0] row_select_word,
  // flags
  output logic exec_flag,
  output logic error_flag,
  output logic irq
);
  import kms_pkg::*;

  // ****************************************
  // parameter checks
  // ****************************************

  generate
    if (ROWS != 8 || COLS != 8) begin : g_bad_size
      $error("kms_top: the matrix is fixed at 8 rows by 8 columns");
    end
    if (DM_LAST < 3 || DM_LAST > 9999) begin : g_bad_dm
      $error("kms_top: DM_LAST must lie in 3..9999");
    end
  endgenerate

  localparam logic [15:0] DM_TOP = 16'(DM_LAST - 3);

  // ****************************************
  // state and phase counter
  // ****************************************

  kms_top_state_t s_q;
  kms_top_state_t s_d;

  kms_phase_if pif ();

  kms_phase #(
    .HOLD(HOLD)
  ) u_phase (
    .clk_sys(clk_sys),
    .rst(rst),
    .pif(pif)
  );

  // ****************************************
  // helpers
  // ****************************************

  // write-one-to-clear with hardware set winning
  function automatic logic [15:0] w1c(
    input logic [15:0] cur,
    input logic [15:0] clr,
    input logic [15:0] set
  );
    return (cur & ~clr) | set;
  endfunction : w1c

  // true when all four nibbles are decimal digits
  function automatic logic bcd_ok(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : bcd_ok

  // binary value of a four digit bcd word
  function automatic logic [15:0] bcd_val(input logic [15:0] v);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 3; i >= 0; i--) begin
      acc = 16'(acc * 16'h000A) + {12'h000, v[i*4 +: 4]};
    end
    return acc;
  endfunction : bcd_val

  // ****************************************
  // execution control
  // ****************************************

  logic run;
  logic ilock;
  logic indir;
  logic ptr_bad;
  logic active;
  logic step;
  logic err_ev;
  logic key_ev;
  logic [63:0] key_set;
  logic [2:0] irq_set;
  logic [3:0] row_idx;

  always_comb begin
    run = s_q.ctrl[`KMS_CTRL_RUN];
    ilock = s_q.ctrl[`KMS_CTRL_ILOCK];
    indir = s_q.ctrl[`KMS_CTRL_INDIR];
    // pointer must be bcd and leave room for four words
    ptr_bad = indir && (!bcd_ok(s_q.dest) || (bcd_val(s_q.dest) > DM_TOP));
    active = run && !ilock;
    step = scan_tick && active && !ptr_bad;
    err_ev = scan_tick && active && ptr_bad;
  end

  assign pif.step = step;

  // ****************************************
  // key detection
  // ****************************************

  always_comb begin
    key_set = 64'h0;
    row_idx = 4'(pif.phase);
    // sample only while a row, not end-of-round, is driven
    if (step && pif.phase != KMS_PH_EOR && pif.row_sel[row_idx]) begin
      for (int c = 0; c < 8; c++) begin
        if (s_q.col_s2[c]) begin
          key_set[{row_idx[2:0], 3'(c)}] = 1'b1;
        end
      end
    end
    key_ev = |key_set;
    irq_set = 3'h0;
    irq_set[`KMS_IRQ_ROUND] = pif.round_done;
    irq_set[`KMS_IRQ_KEY] = key_ev;
    irq_set[`KMS_IRQ_ERR] = err_ev;
  end

  // ****************************************
  // register writes and state update
  // ****************************************

  logic [15:0] clr16;
  logic [15:0] clr_w;
  logic [15:0] clr_i;
  logic [15:0] nxt_i;

  always_comb begin
    s_d = s_q;
    clr16 = reg_wdata[15:0];
    clr_w = 16'h0000;
    clr_i = 16'h0000;
    nxt_i = 16'h0000;
    s_d.col_s1 = column_input_word;
    s_d.col_s2 = s_q.col_s1;
    s_d.rdata = 32'h0000_0000;

    // key map, sticky until software clears a bit
    for (int w = 0; w < 4; w++) begin
      clr_w = 16'h0000;
      if (reg_wr && reg_addr == 8'(`KMS_OFS_MAP0 + 8'(w * 4))) begin
        clr_w = clr16;
      end
      s_d.key_map[w*16 +: 16] = w1c(s_q.key_map[w*16 +: 16], clr_w, key_set[w*16 +: 16]);
    end

    // error flag follows each execution attempt
    if (scan_tick && active) begin
      s_d.err = ptr_bad;
    end

    // interrupt status
    begin
      clr_i = 16'h0000;
      if (reg_wr && reg_addr == `KMS_OFS_IRQ_STAT) begin
        clr_i = clr16;
      end
      nxt_i = w1c({13'h0000, s_q.irq_stat}, clr_i, {13'h0000, irq_set});
      s_d.irq_stat = nxt_i[2:0];
    end

    // plain writes
    if (reg_wr) begin
      if (reg_addr == `KMS_OFS_CTRL) begin
        s_d.ctrl = reg_wdata[2:0];
      end else if (reg_addr == `KMS_OFS_IRQ_MASK) begin
        s_d.irq_mask = reg_wdata[2:0];
      end else if (reg_addr == `KMS_OFS_DEST) begin
        s_d.dest = reg_wdata[15:0];
      end
    end

    // read data, valid in the cycle after the strobe only
    if (reg_rd) begin
      if (reg_addr == `KMS_OFS_CTRL) begin
        s_d.rdata = {29'h0, s_q.ctrl};
      end else if (reg_addr == `KMS_OFS_STATUS) begin
        s_d.rdata = 32'h0;
        s_d.rdata[`KMS_ST_BUSY] = active;
        s_d.rdata[`KMS_ST_ERR] = s_q.err;
        s_d.rdata[`KMS_ST_PHASE_LO +: 4] = pif.phase;
      end else if (reg_addr == `KMS_OFS_MAP0) begin
        s_d.rdata = {16'h0, s_q.key_map[15:0]};
      end else if (reg_addr == `KMS_OFS_MAP1) begin
        s_d.rdata = {16'h0, s_q.key_map[31:16]};
      end else if (reg_addr == `KMS_OFS_MAP2) begin
        s_d.rdata = {16'h0, s_q.key_map[47:32]};
      end else if (reg_addr == `KMS_OFS_MAP3) begin
        s_d.rdata = {16'h0, s_q.key_map[63:48]};
      end else if (reg_addr == `KMS_OFS_IRQ_STAT) begin
        s_d.rdata = {29'h0, s_q.irq_stat};
      end else if (reg_addr == `KMS_OFS_IRQ_MASK) begin
        s_d.rdata = {29'h0, s_q.irq_mask};
      end else if (reg_addr == `KMS_OFS_DEST) begin
        s_d.rdata = {16'h0, s_q.dest};
      end else begin
        // unmapped addresses read as zero
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.col_s1 <= 8'h00;
      s_q.col_s2 <= 8'h00;
      s_q.key_map <= 64'h0;
      s_q.ctrl <= `KMS_CTRL_RST;
      s_q.dest <= `KMS_DEST_RST;
      s_q.irq_stat <= `KMS_IRQ_RST;
      s_q.irq_mask <= `KMS_IRQ_RST;
      s_q.err <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign reg_rdata = s_q.rdata;
  assign row_select_word = pif.row_sel;
  assign exec_flag = active;
  assign error_flag = s_q.err;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule : kms_top

/* tb/kms_key_matrix.sv */
// passive 8 x 8 key switch matrix on the scanner pins
`timescale 1ns/100ps
module kms_key_matrix (
  // scanner drive
  input wire logic [8:0] row_select_word,
  // keys held down, bit row*8+col
  input wire logic [63:0] keys_down,
  // contacts back to the scanner
  output logic [7:0] column_input_word
);
  // a driven row passes its closed switches, open columns read low
  always_comb begin
    column_input_word = 8'h00;
    for (int r = 0; r < 8; r++) begin
      if (row_select_word[r]) column_input_word |= keys_down[r*8 +: 8];
    end
  end
endmodule : kms_key_matrix

/* tb/kms_top_props.sv */
// assertion checker for the key matrix scanner
`timescale 1ns/100ps
module kms_top_props #(
  parameter int HOLD = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // scan
  input wire logic scan_tick,
  input wire logic [8:0] row_select_word,
  input wire logic exec_flag,
  input wire logic error_flag
);
  // ****************
  // step tracking
  // ****************
  logic tick_q;
  int n_q;
  logic step_seen;
  // error_flag after a tick tells whether that tick was a real step
  assign step_seen = tick_q & ~error_flag;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_q <= 1'b0;
      n_q <= 0;
    end else begin
      tick_q <= scan_tick & exec_flag;
      if (step_seen) n_q <= (n_q == HOLD - 1) ? 0 : n_q + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_onehot; $onehot(row_select_word); endproperty
  a_onehot: assert property (p_onehot) else $error("row drive not one-hot");
  property p_nostep; !step_seen |-> $stable(row_select_word); endproperty
  a_nostep: assert property (p_nostep) else $error("row moved without step");
  property p_hold; $changed(row_select_word) |-> step_seen && n_q == HOLD - 1; endproperty
  a_hold: assert property (p_hold) else $error("row held wrong count");
  property p_order;
    $changed(row_select_word) && !$past(row_select_word[8])
      |-> row_select_word == {$past(row_select_word[7:0]), 1'b0};
  endproperty
  a_order: assert property (p_order) else $error("row order broken");
  property p_wrap;
    $changed(row_select_word) && $past(row_select_word[8]) |-> row_select_word == 9'h001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no restart after end of round");
  property p_exec; $changed(exec_flag) |-> $past(reg_wr); endproperty
  a_exec: assert property (p_exec) else $error("exec flag moved alone");
  property p_err; $changed(error_flag) |-> tick_q; endproperty
  a_err: assert property (p_err) else $error("error flag moved without tick");
  property p_rdidle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data outside slot");
endmodule : kms_top_props
bind kms_top kms_top_props #(.HOLD(HOLD)) u_props (.clk_sys, .rst, .reg_wr, .reg_rd,
  .reg_rdata, .scan_tick, .row_select_word, .exec_flag, .error_flag);

/* tb/kms_top_test.sv */
// self-checking testbench of the key matrix scanner
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module kms_top_test;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, scan_tick = 1'b0;
  logic [7:0] reg_addr = 8'h00, cols;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v, seed = 32'h000175A4;
  logic [8:0] row_select_word;
  logic exec_flag, error_flag, irq, ok = 1'b0, rnd_irq = 1'b0;
  logic [63:0] keys = 64'h0, mmap = 64'h0;
  logic [15:0] dests [3] = '{16'h00A0, 16'h9997, 16'h9996};
  int mismatches = 0, n_compared = 0, ph = 0, hc = 0;
  kms_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scan_tick, .column_input_word(cols), .row_select_word, .exec_flag, .error_flag, .irq);
  kms_key_matrix u_keys (.row_select_word, .keys_down(keys), .column_input_word(cols));
  always #12.5 clk_sys = ~clk_sys;
  // ****************
  // bus and tick tasks
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask : rd
  // one execution; the model steps alongside when ok is set
  task automatic tick();
    @(posedge clk_sys);
    scan_tick <= 1'b1;
    @(posedge clk_sys);
    scan_tick <= 1'b0;
    if (ok) begin
      if (ph < 8) mmap[ph*8 +: 8] |= keys[ph*8 +: 8];
      hc++;
      if (hc == 3) begin
        hc = 0;
        if (ph == 8) rnd_irq = 1'b1;
        ph = (ph + 1) % 9;
      end
    end
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(row_select_word, 9'h001 << ph)
  endtask : tick
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // ****************
  // scenarios
  // ****************
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK(row_select_word, 9'h001)
    rd(8'hFC);
    `CHK(rd_v, 32'h0)
    repeat (4) tick();
    wr(8'h1C, 32'h1);
    wr(8'h00, 32'h1);
    ok = 1'b1;
    `CHK(exec_flag, 1'b1)
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      keys[31:0] <= seed;
      seed = lfsr(seed);
      keys[63:32] <= seed;
      repeat (3) @(posedge clk_sys);
      repeat (27) tick();
      `CHK(irq, rnd_irq)
      for (int w = 0; w < 4; w++) begin
        rd(8'h08 + 8'(w * 4));
        `CHK(rd_v, {16'h0, mmap[w*16 +: 16]})
        wr(8'h08 + 8'(w * 4), 32'h0000FFFF);
      end
      mmap = 64'h0;
      wr(8'h18, 32'h1);
      rnd_irq = 1'b0;
      `CHK(irq, 1'b0)
    end
    wr(8'h00, 32'h3);
    ok = 1'b0;
    `CHK(exec_flag, 1'b0)
    repeat (4) tick();
    for (int i = 0; i < 3; i++) begin
      wr(8'h20, {16'h0, dests[i]});
      wr(8'h00, 32'h5);
      ok = (i == 2);
      tick();
      `CHK(error_flag, ~ok)
    end
    rd(8'h04);
    `CHK(rd_v, {20'h0, 4'(ph), 6'h0, 1'b0, 1'b1})
    wr(8'h1C, 32'h4);
    `CHK(irq, 1'b1)
    wr(8'h18, 32'h4);
    `CHK(irq, 1'b0)
    test_done();
  end
endmodule : kms_top_test
